// [design/tec_pkg.sv]
// package for the 16-bit timer/event counter: offsets, fields, resets, types
// assumes a 10 MHz system clock and the plain register port of the top module
package tec_pkg;
  // register offsets (word index on the plain port)
  localparam logic [3:0] OFS_MODE = 4'h0;
  localparam logic [3:0] OFS_PRESCALE = 4'h1;
  localparam logic [3:0] OFS_PERIOD = 4'h2;
  localparam logic [3:0] OFS_DUTY = 4'h3;
  localparam logic [3:0] OFS_COUNT = 4'h4;
  localparam logic [3:0] OFS_CAPT_A = 4'h5;
  localparam logic [3:0] OFS_CAPT_B = 4'h6;
  localparam logic [3:0] OFS_OUTCTL = 4'h7;
  localparam logic [3:0] OFS_IRQ_STAT = 4'h8;
  localparam logic [3:0] OFS_IRQ_EN = 4'h9;
  localparam logic [3:0] OFS_IRQ_CLR = 4'ha;
  // mode register fields
  localparam int MODE_RUN_LO = 0;
  localparam int MODE_RUN_HI = 1;
  localparam int MODE_FUNC_LO = 2;
  localparam int MODE_EDGE_LO = 4;
  localparam int MODE_PIN_SEL = 6;
  // output control fields
  localparam int OC_INV_EN = 0;
  localparam int OC_OUT_EN = 1;
  localparam int OC_OS_TRIG = 2;
  // irq status bits
  localparam int IRQ_DUTY = 0;
  localparam int IRQ_PERIOD = 1;
  localparam int IRQ_CAPT_A = 2;
  localparam int IRQ_CAPT_B = 3;
  localparam int IRQ_W = 4;
  // run codes
  localparam logic [1:0] RUN_STOP = 2'h0;
  // reset values
  localparam logic [15:0] RST_16 = 16'h0000;
  localparam logic [7:0] RST_MODE = 8'h00;
  localparam logic [2:0] RST_PRESCALE = 3'h0;
  localparam logic [2:0] RST_OUTCTL = 3'h0;
  localparam logic [IRQ_W-1:0] RST_IRQ = 4'h0;
  localparam int PRE_W = 8;
  localparam logic [PRE_W-1:0] PRE_ONE = 8'h01;
  localparam logic [15:0] CNT_ONE = 16'h0001;
  // timing
  localparam int CLK_NS = 100;

  // functional modes
  typedef enum logic [1:0] {
    FN_FREE  = 2'b00,
    FN_PULSE = 2'b01,
    FN_EVENT = 2'b10,
    FN_ONESHOT = 2'b11
  } tec_func_t;

  // valid edge selections
  typedef enum logic [1:0] {
    EDGE_FALL = 2'b00,
    EDGE_RISE = 2'b01,
    EDGE_NONE = 2'b10,
    EDGE_BOTH = 2'b11
  } tec_edge_t;

  // one-shot sequencer states
  typedef enum logic [1:0] {
    OS_IDLE = 2'b00,
    OS_DELAY = 2'b01,
    OS_PULSE = 2'b10
  } tec_os_t;

  // register bus request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] addr;
    logic [15:0] wdata;
  } tec_bus_t;

  // edge detector outputs for both pins
  typedef struct packed {
    logic rise_a;
    logic fall_a;
    logic rise_b;
    logic fall_b;
    logic level_a;
  } tec_edges_t;
endpackage

// [design/tec_edge_det.sv]
// pin synchroniser and edge detector for the two capture inputs
// assumes pins are sampled on clk_in; edges reported only while armed
`timescale 1ns/1ps
module tec_edge_det (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic run_in,
  input wire logic sample_in,
  input wire logic pin_a_in,
  input wire logic pin_b_in,
  output tec_pkg::tec_edges_t edges_out
);
  logic [1:0] sync_a_r, sync_a_nxt;
  logic [1:0] sync_b_r, sync_b_nxt;
  logic prev_a_r, prev_a_nxt;
  logic prev_b_r, prev_b_nxt;
  logic run_d_r, run_d_nxt;
  logic boot_r, boot_nxt;
  logic restart;

  // next-state: two-stage sync, previous level, reset-seeded history
  always_comb begin
    sync_a_nxt = {sync_a_r[0], pin_a_in};
    sync_b_nxt = {sync_b_r[0], pin_b_in};
    run_d_nxt = run_in;
    boot_nxt = boot_r;
    prev_a_nxt = prev_a_r;
    prev_b_nxt = prev_b_r;
    restart = run_in && !run_d_r && !boot_r;
    if (restart) begin
      // restart: take current level, report nothing on this sample
      prev_a_nxt = sync_a_r[1]; // R02
      prev_b_nxt = sync_b_r[1]; // R02
    end else if (sample_in) begin
      prev_a_nxt = sync_a_r[1]; // R16
      prev_b_nxt = sync_b_r[1];
    end
    if (run_in && sample_in) begin
      boot_nxt = 1'b0;
    end
    edges_out.level_a = sync_a_r[1];
    edges_out.rise_a = run_in && sample_in && !restart && sync_a_r[1] && !prev_a_r; // R01 R02
    edges_out.fall_a = run_in && sample_in && !restart && !sync_a_r[1] && prev_a_r;
    edges_out.rise_b = run_in && sample_in && !restart && sync_b_r[1] && !prev_b_r; // R02
    edges_out.fall_b = run_in && sample_in && !restart && !sync_b_r[1] && prev_b_r;
  end

  // registers; history after reset is low so a high pin shows a rise
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      sync_a_r <= 2'h0;
      sync_b_r <= 2'h0;
      prev_a_r <= 1'b0; // R01
      prev_b_r <= 1'b0;
      run_d_r <= 1'b0;
      boot_r <= 1'b1;
    end else begin
      sync_a_r <= sync_a_nxt;
      sync_b_r <= sync_b_nxt;
      prev_a_r <= prev_a_nxt;
      prev_b_r <= prev_b_nxt;
      run_d_r <= run_d_nxt;
      boot_r <= boot_nxt;
    end
  end

  // a restarted run with a high pin gives no rise on its first sample
  restart_no_rise_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (restart && sync_a_r[1]) |-> !edges_out.rise_a ##1 !edges_out.rise_a) // R02
    else $error("rise reported after restart with high pin");
endmodule

// [design/tec_timer.sv]
// 16-bit timer/event counter: counter, compares, capture, pulse and one-shot
// assumes synchronous register port and pins synchronous to clk_in (10 MHz)
`timescale 1ns/1ps
// Behaviour
// R01: high pin after reset gives immediate rise
// R02: restart with high pin gives no rise
// R03: shared pin is input b or output
// R04: software keeps duty below period
// R05: pulse period and duty plus one
// R06: software follows duty rewrite sequence
// R07: duty match toggles output when enabled
// R08: duty match sets sticky masked flag
// R09: software sets both capture pins as inputs
// R10: event count read from count register
// R11: no retrigger while one-shot runs
// R12: one-shot trigger bit self-clears, reads zero
// R13: nonzero run code starts counting
// R14: external trigger held over two count clocks
// R15: period match clears count, toggles output
// R16: pins synchronised and sampled per count clock
module tec_timer (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic [3:0] addr_in,
  input wire logic [15:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [15:0] rdata_out,
  input wire logic trigger_capture_in_a,
  input wire logic shared_port_pin_in,
  output logic unit1_timer_output_out,
  output logic timer_output_oe_out,
  output logic duty_match_irq_out
);
  tec_pkg::tec_bus_t bus;
  tec_pkg::tec_edges_t edg;
  tec_pkg::tec_func_t func;
  tec_pkg::tec_edge_t esel;
  tec_pkg::tec_os_t os_r, os_nxt;
  logic [7:0] mode_r, mode_nxt;
  logic [2:0] pre_r, pre_nxt;
  logic [2:0] oc_r, oc_nxt;
  logic [15:0] period_compare_reg_r, period_nxt;
  logic [15:0] duty_compare_reg_r, duty_nxt;
  logic [15:0] count_value_reg_r, count_nxt;
  logic [15:0] capt_a_r, capt_a_nxt;
  logic [15:0] capt_b_r, capt_b_nxt;
  logic [tec_pkg::IRQ_W-1:0] stat_r, stat_nxt;
  logic [tec_pkg::IRQ_W-1:0] en_r, en_nxt;
  logic [tec_pkg::PRE_W-1:0] div_r, div_nxt;
  logic [15:0] rdata_r, rdata_nxt;
  logic out_r, out_nxt;
  logic oe_r, oe_nxt;
  logic irq_r, irq_nxt;
  logic run, tick, pin_is_out, edge_a, edge_b, trig_os;
  logic duty_hit, per_hit, pulse_go;
  logic [tec_pkg::IRQ_W-1:0] ev;
  logic [tec_pkg::PRE_W-1:0] div_lim;

  // edge selection decode used for both pins
  function automatic logic edge_ok(tec_pkg::tec_edge_t s, logic r, logic f);
    edge_ok = ((s == tec_pkg::EDGE_RISE) && r) || ((s == tec_pkg::EDGE_FALL) && f) ||
              ((s == tec_pkg::EDGE_BOTH) && (r || f));
  endfunction

  assign bus = '{wr: wr_in, rd: rd_in, addr: addr_in, wdata: wdata_in};
  assign run = (mode_r[tec_pkg::MODE_RUN_HI:tec_pkg::MODE_RUN_LO] != tec_pkg::RUN_STOP); // R13
  assign func = tec_pkg::tec_func_t'(mode_r[tec_pkg::MODE_FUNC_LO+1:tec_pkg::MODE_FUNC_LO]);
  assign esel = tec_pkg::tec_edge_t'(mode_r[tec_pkg::MODE_EDGE_LO+1:tec_pkg::MODE_EDGE_LO]);
  // shared pin: output when selected, else second capture source
  assign pin_is_out = mode_r[tec_pkg::MODE_PIN_SEL]; // R03

  // prescaler: count clock is clk divided by 2^sel
  always_comb begin
    div_lim = tec_pkg::PRE_W'((tec_pkg::PRE_ONE << pre_r) - tec_pkg::PRE_ONE);
    tick = run && (div_r >= div_lim);
    div_nxt = (!run || tick) ? '0 : tec_pkg::PRE_W'(div_r + tec_pkg::PRE_ONE);
  end

  tec_edge_det u_edge (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .run_in(run),
    .sample_in(tick),
    .pin_a_in(trigger_capture_in_a),
    .pin_b_in(shared_port_pin_in & ~pin_is_out), // R03
    .edges_out(edg)
  );

  assign edge_a = edge_ok(esel, edg.rise_a, edg.fall_a);
  assign edge_b = !pin_is_out && edge_ok(esel, edg.rise_b, edg.fall_b); // R03
  assign duty_hit = tick && (count_value_reg_r == duty_compare_reg_r);
  assign per_hit = tick && (count_value_reg_r == period_compare_reg_r);
  assign trig_os = bus.wr && (bus.addr == tec_pkg::OFS_OUTCTL) &&
                   bus.wdata[tec_pkg::OC_OS_TRIG] && (func == tec_pkg::FN_ONESHOT);
  // a start into pulse mode opens with the high phase of the period
  assign pulse_go = bus.wr && (bus.addr == tec_pkg::OFS_MODE) &&
                    (bus.wdata[tec_pkg::MODE_RUN_LO +: 2] != tec_pkg::RUN_STOP) &&
                    (bus.wdata[tec_pkg::MODE_FUNC_LO +: 2] == tec_pkg::FN_PULSE);

  // counter, output flip-flop and one-shot sequencer
  always_comb begin
    count_nxt = count_value_reg_r;
    out_nxt = out_r;
    os_nxt = os_r;
    if (!run) begin
      count_nxt = tec_pkg::RST_16;
      os_nxt = tec_pkg::OS_IDLE;
      out_nxt = pulse_go; // R05: idle low, high duty+1 counts first
    end else begin
      unique case (func)
        tec_pkg::FN_EVENT: begin
          if (edge_a) begin
            count_nxt = count_value_reg_r + tec_pkg::CNT_ONE; // R10
          end
        end
        tec_pkg::FN_PULSE: begin
          if (per_hit) begin
            count_nxt = tec_pkg::RST_16; // R15
            out_nxt = ~out_r; // R05
          end else if (tick) begin
            count_nxt = count_value_reg_r + tec_pkg::CNT_ONE;
          end
          if (duty_hit && oc_r[tec_pkg::OC_INV_EN] && !per_hit) begin
            out_nxt = ~out_r; // R07
          end
        end
        tec_pkg::FN_ONESHOT: begin
          unique case (os_r)
            tec_pkg::OS_IDLE: begin
              if (trig_os || edge_a) begin // R11
                count_nxt = tec_pkg::RST_16;
                os_nxt = tec_pkg::OS_DELAY;
              end
            end
            tec_pkg::OS_DELAY: begin
              if (tick) begin
                count_nxt = count_value_reg_r + tec_pkg::CNT_ONE;
              end
              if (duty_hit) begin
                out_nxt = 1'b1;
                os_nxt = tec_pkg::OS_PULSE;
              end
            end
            tec_pkg::OS_PULSE: begin
              if (tick) begin
                count_nxt = count_value_reg_r + tec_pkg::CNT_ONE;
              end
              if (per_hit) begin
                out_nxt = 1'b0;
                os_nxt = tec_pkg::OS_IDLE;
              end
            end
            default: begin
              os_nxt = tec_pkg::OS_IDLE;
            end
          endcase
        end
        tec_pkg::FN_FREE: begin
          if (tick) begin
            count_nxt = count_value_reg_r + tec_pkg::CNT_ONE;
          end
        end
      endcase
    end
    oe_nxt = pin_is_out && oc_r[tec_pkg::OC_OUT_EN]; // R03
  end

  // capture in free-running mode: pin a edge into capture a, pin b edge into capture b
  always_comb begin
    capt_a_nxt = capt_a_r;
    capt_b_nxt = capt_b_r;
    if (func == tec_pkg::FN_FREE && edge_a) begin
      capt_a_nxt = count_value_reg_r;
    end
    if (func == tec_pkg::FN_FREE && edge_b) begin
      capt_b_nxt = count_value_reg_r;
    end
  end

  // register writes; trigger bit is never stored
  always_comb begin
    mode_nxt = mode_r;
    pre_nxt = pre_r;
    oc_nxt = oc_r;
    period_nxt = period_compare_reg_r;
    duty_nxt = duty_compare_reg_r;
    en_nxt = en_r;
    if (bus.wr) begin
      unique case (bus.addr)
        tec_pkg::OFS_MODE: mode_nxt = bus.wdata[7:0];
        tec_pkg::OFS_PRESCALE: pre_nxt = bus.wdata[2:0];
        tec_pkg::OFS_PERIOD: period_nxt = bus.wdata;
        tec_pkg::OFS_DUTY: duty_nxt = bus.wdata;
        tec_pkg::OFS_OUTCTL: oc_nxt = {1'b0, bus.wdata[1:0]}; // R12
        tec_pkg::OFS_IRQ_EN: en_nxt = bus.wdata[tec_pkg::IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  // sticky status: set wins over clear
  always_comb begin
    ev = '0;
    ev[tec_pkg::IRQ_DUTY] = duty_hit && run; // R08
    ev[tec_pkg::IRQ_PERIOD] = per_hit && run;
    ev[tec_pkg::IRQ_CAPT_A] = edge_a && func == tec_pkg::FN_FREE;
    ev[tec_pkg::IRQ_CAPT_B] = edge_b && func == tec_pkg::FN_FREE;
    stat_nxt = stat_r;
    if (bus.wr && bus.addr == tec_pkg::OFS_IRQ_CLR) begin
      stat_nxt = stat_r & ~bus.wdata[tec_pkg::IRQ_W-1:0];
    end
    stat_nxt = stat_nxt | ev; // R08
    irq_nxt = |(stat_nxt & en_nxt); // R08
  end

  // read mux; unmapped and write-only offsets read zero
  always_comb begin
    rdata_nxt = '0;
    if (bus.rd) begin
      unique case (bus.addr)
        tec_pkg::OFS_MODE: rdata_nxt = {8'h00, mode_r};
        tec_pkg::OFS_PRESCALE: rdata_nxt = {13'h0000, pre_r};
        tec_pkg::OFS_PERIOD: rdata_nxt = period_compare_reg_r;
        tec_pkg::OFS_DUTY: rdata_nxt = duty_compare_reg_r;
        tec_pkg::OFS_COUNT: rdata_nxt = count_value_reg_r; // R10
        tec_pkg::OFS_CAPT_A: rdata_nxt = capt_a_r;
        tec_pkg::OFS_CAPT_B: rdata_nxt = capt_b_r;
        tec_pkg::OFS_OUTCTL: rdata_nxt = {13'h0000, oc_r}; // R12
        tec_pkg::OFS_IRQ_STAT: rdata_nxt = {12'h000, stat_r};
        tec_pkg::OFS_IRQ_EN: rdata_nxt = {12'h000, en_r};
        default: rdata_nxt = '0;
      endcase
    end
  end

  // register all state
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      mode_r <= tec_pkg::RST_MODE;
      pre_r <= tec_pkg::RST_PRESCALE;
      oc_r <= tec_pkg::RST_OUTCTL;
      period_compare_reg_r <= tec_pkg::RST_16;
      duty_compare_reg_r <= tec_pkg::RST_16;
      count_value_reg_r <= tec_pkg::RST_16;
      capt_a_r <= tec_pkg::RST_16;
      capt_b_r <= tec_pkg::RST_16;
      stat_r <= tec_pkg::RST_IRQ;
      en_r <= tec_pkg::RST_IRQ;
      div_r <= '0;
      rdata_r <= tec_pkg::RST_16;
      out_r <= 1'b0;
      oe_r <= 1'b0;
      irq_r <= 1'b0;
      os_r <= tec_pkg::OS_IDLE;
    end else begin
      mode_r <= mode_nxt;
      pre_r <= pre_nxt;
      oc_r <= oc_nxt;
      period_compare_reg_r <= period_nxt;
      duty_compare_reg_r <= duty_nxt;
      count_value_reg_r <= count_nxt;
      capt_a_r <= capt_a_nxt;
      capt_b_r <= capt_b_nxt;
      stat_r <= stat_nxt;
      en_r <= en_nxt;
      div_r <= div_nxt;
      rdata_r <= rdata_nxt;
      out_r <= out_nxt;
      oe_r <= oe_nxt;
      irq_r <= irq_nxt;
      os_r <= os_nxt;
    end
  end

  assign rdata_out = rdata_r;
  assign unit1_timer_output_out = out_r;
  assign timer_output_oe_out = oe_r;
  assign duty_match_irq_out = irq_r;

  // period match in pulse mode restarts from zero and toggles
  sequence per_match_s;
    run && func == tec_pkg::FN_PULSE && per_hit;
  endsequence
  period_wrap_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    per_match_s |=> count_value_reg_r == tec_pkg::RST_16 && out_r != $past(out_r)) // R15
    else $error("period match did not clear and toggle");
  duty_toggle_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (run && func == tec_pkg::FN_PULSE && duty_hit && !per_hit && oc_r[tec_pkg::OC_INV_EN]
     && !bus.wr) |=> out_r != $past(out_r)) // R07
    else $error("duty match did not toggle output");
  duty_hold_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (run && func == tec_pkg::FN_PULSE && !per_hit && !oc_r[tec_pkg::OC_INV_EN])
    |=> $stable(out_r)) // R07
    else $error("output changed with inversion off");
  duty_flag_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (duty_hit && run) |=> stat_r[tec_pkg::IRQ_DUTY]) // R08
    else $error("duty flag not set");
  irq_gate_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    ##1 duty_match_irq_out == |($past(stat_nxt) & $past(en_nxt))) // R08
    else $error("interrupt output wrong");
  trig_zero_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (bus.rd && bus.addr == tec_pkg::OFS_OUTCTL) |=> !rdata_out[tec_pkg::OC_OS_TRIG]) // R12
    else $error("trigger bit read back set");
  start_run_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (!run && bus.wr && bus.addr == tec_pkg::OFS_MODE && bus.wdata[1:0] != tec_pkg::RUN_STOP)
    |=> run) // R13
    else $error("counter did not start");
  shared_pin_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    timer_output_oe_out |-> $past(pin_is_out)) // R03
    else $error("pin driven while used as input");
  sample_tick_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (edg.rise_a || edg.fall_a) |-> tick) // R16
    else $error("edge outside count clock sample");
  boot_rise_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (tick && edg.rise_a) |-> edg.level_a) // R01
    else $error("rise without high level");
endmodule

// [verif/tec_pin_model.sv]
// external signal sources on both capture pins and the load on the shared pin
// assumes one clock; the bench drives it through task calls
`timescale 1ns/1ps
module tec_pin_model (
  input wire logic clk_in,
  input wire logic timer_out_in,
  input wire logic oe_in,
  output logic pin_a_out,
  output logic pin_b_out
);
  logic src_b;
  // both pins start as plain low inputs
  initial begin
    pin_a_out = 1'b0;
    src_b = 1'b0;
  end
  // shared pin follows the block while it drives, else our source
  assign pin_b_out = oe_in ? timer_out_in : src_b;
  // level change on pin a just after an edge
  task automatic set_a(input logic v);
    @(posedge clk_in);
    pin_a_out <= v;
  endtask
  // level change on the shared pin's own source
  task automatic set_b(input logic v);
    @(posedge clk_in);
    src_b <= v;
  endtask
  // n pulses, each level held for hold+1 clock cycles
  task automatic pulse_a(input int n, input int hold);
    repeat (n) begin
      set_a(1'b1);
      repeat (hold) @(posedge clk_in);
      set_a(1'b0);
      repeat (hold) @(posedge clk_in);
    end
  endtask
  // short spike between two sampling edges
  task automatic glitch_a();
    @(posedge clk_in);
    #30 pin_a_out = 1'b1;
    #40 pin_a_out = 1'b0;
  endtask
  // wait for the load to see level v, then count cycles it stays there
  task automatic span(input logic v, output int t);
    int g;
    g = 0;
    t = 0;
    #1;
    while (timer_out_in !== v && g < 3000) begin
      @(posedge clk_in);
      #1;
      g++;
    end
    while (timer_out_in === v && t < 3000) begin
      @(posedge clk_in);
      #1;
      t++;
    end
  endtask
endmodule

// [verif/tec_timer_tb.sv]
// self-checking bench for the timer: registers, capture, event, pulse, one-shot
// assumes the pin model beside it and a 10 MHz clock
`timescale 1ns/1ps
module tec_timer_tb;
  logic clk_in, rst_b_in, wr_in, rd_in, pin_a, pin_b, tout, toe, irq;
  logic [3:0] addr_in;
  logic [15:0] wdata_in, rdata_out, got, g2;
  int errors, comparisons, p, d, n, k, hi, lo, x;
  tec_timer uut (.clk_in(clk_in), .rst_b_in(rst_b_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .trigger_capture_in_a(pin_a), .shared_port_pin_in(pin_b),
    .unit1_timer_output_out(tout), .timer_output_oe_out(toe), .duty_match_irq_out(irq));
  tec_pin_model pm (.clk_in(clk_in), .timer_out_in(tout), .oe_in(toe),
    .pin_a_out(pin_a), .pin_b_out(pin_b));
  // 100 ns clock
  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end
  // verdict and end of run
  task automatic close_out();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic check(input logic [15:0] g, input logic [15:0] e);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask
  // one-cycle register write and read
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= v;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] v);
    @(posedge clk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 v = rdata_out;
  endtask
  task automatic tick(input int c);
    repeat (c) @(posedge clk_in);
  endtask
  // mode word from its fields
  function automatic logic [15:0] mode_w(input tec_pkg::tec_func_t f,
    input tec_pkg::tec_edge_t e, input logic s, input logic [1:0] r);
    mode_w = 16'h0000;
    mode_w[tec_pkg::MODE_RUN_LO +: 2] = r;
    mode_w[tec_pkg::MODE_FUNC_LO +: 2] = f;
    mode_w[tec_pkg::MODE_EDGE_LO +: 2] = e;
    mode_w[tec_pkg::MODE_PIN_SEL] = s;
  endfunction
  function automatic logic [15:0] bitv(input int i);
    bitv = 16'h0001 << i;
  endfunction
  // watchdog far beyond the expected run of under a thousand cycles
  initial begin
    tick(40000);
    errors++;
    $display("BAD %0t watchdog", $time);
    close_out();
  end
  // main sequence
  initial begin
    rst_b_in = 1'b0;
    wr_in = 1'b0;
    rd_in = 1'b0;
    addr_in = 4'h0;
    wdata_in = 16'h0000;
    errors = 0;
    comparisons = 0;
    x = $urandom(24);
    pm.set_a(1'b1);
    tick(11);
    rst_b_in <= 1'b1;
    // reset values of every register and an unmapped offset
    for (int a = 0; a < 16; a += (a == 10) ? 5 : 1) begin
      rd(4'(a), got);
      check(got, 16'h0000);
    end
    // pin high since reset: rise seen at first start
    wr(tec_pkg::OFS_IRQ_EN, 16'h000f);
    wr(tec_pkg::OFS_MODE, mode_w(tec_pkg::FN_FREE, tec_pkg::EDGE_RISE, 1'b0, 2'h1));
    tick(8);
    rd(tec_pkg::OFS_IRQ_STAT, got);
    check(got & bitv(tec_pkg::IRQ_CAPT_A), bitv(tec_pkg::IRQ_CAPT_A));
    check({15'h0000, toe}, 16'h0000);
    // low sampled, stop, pin rises while stopped: restart shows no rise
    pm.set_a(1'b0);
    tick(6);
    wr(tec_pkg::OFS_MODE, 16'h0000);
    wr(tec_pkg::OFS_IRQ_CLR, 16'h000f);
    pm.set_a(1'b1);
    tick(4);
    wr(tec_pkg::OFS_MODE, mode_w(tec_pkg::FN_FREE, tec_pkg::EDGE_RISE, 1'b0, 2'h1));
    tick(8);
    rd(tec_pkg::OFS_IRQ_STAT, got);
    check(got & bitv(tec_pkg::IRQ_CAPT_A), 16'h0000);
    pm.set_a(1'b0);
    tick(6);
    pm.set_a(1'b1);
    tick(8);
    rd(tec_pkg::OFS_IRQ_STAT, got);
    check(got & bitv(tec_pkg::IRQ_CAPT_A), bitv(tec_pkg::IRQ_CAPT_A));
    // shared pin as input: its rise reaches capture b
    pm.set_b(1'b1);
    tick(8);
    rd(tec_pkg::OFS_IRQ_STAT, got);
    check(got & bitv(tec_pkg::IRQ_CAPT_B), bitv(tec_pkg::IRQ_CAPT_B));
    // counter runs while started and clears to zero when stopped
    rd(tec_pkg::OFS_COUNT, got);
    k = 2 + $urandom % 20;
    tick(k);
    rd(tec_pkg::OFS_COUNT, g2);
    check(g2, got + 16'(k + 2));
    wr(tec_pkg::OFS_MODE, 16'h0000);
    rd(tec_pkg::OFS_COUNT, got);
    tick(k);
    rd(tec_pkg::OFS_COUNT, g2);
    check(g2, got);
    // event counting, with a spike that must be ignored
    pm.set_a(1'b0);
    wr(tec_pkg::OFS_MODE, mode_w(tec_pkg::FN_EVENT, tec_pkg::EDGE_RISE, 1'b0, 2'h1));
    tick(6);
    rd(tec_pkg::OFS_COUNT, got);
    n = 1 + $urandom % 8;
    pm.pulse_a(n, 3 + $urandom % 4);
    pm.glitch_a();
    tick(6);
    rd(tec_pkg::OFS_COUNT, g2);
    check(g2, got + 16'(n));
    // pulse output with random period and duty
    wr(tec_pkg::OFS_MODE, 16'h0000);
    p = 6 + $urandom % 20;
    d = 1 + $urandom % (p - 1);
    wr(tec_pkg::OFS_PERIOD, 16'(p));
    wr(tec_pkg::OFS_DUTY, 16'(d));
    wr(tec_pkg::OFS_IRQ_CLR, 16'h000f);
    wr(tec_pkg::OFS_IRQ_EN, bitv(tec_pkg::IRQ_DUTY));
    wr(tec_pkg::OFS_OUTCTL, 16'h0003);
    wr(tec_pkg::OFS_MODE, mode_w(tec_pkg::FN_PULSE, tec_pkg::EDGE_NONE, 1'b1, 2'h1));
    tick(2);
    check({15'h0000, toe}, 16'h0001);
    pm.span(1'b0, x);
    pm.span(1'b1, hi);
    pm.span(1'b0, lo);
    check(16'(hi), 16'(d + 1));
    check(16'(hi + lo), 16'(p + 1));
    check({15'h0000, irq}, 16'h0001);
    wr(tec_pkg::OFS_IRQ_EN, 16'h0000);
    tick(2);
    check({15'h0000, irq}, 16'h0000);
    rd(tec_pkg::OFS_IRQ_STAT, got);
    check(got & bitv(tec_pkg::IRQ_DUTY), bitv(tec_pkg::IRQ_DUTY));
    // duty rewrite while running, in the safe order
    wr(tec_pkg::OFS_OUTCTL, 16'h0002);
    d = 1 + $urandom % (p - 1);
    wr(tec_pkg::OFS_DUTY, 16'(d));
    tick(1);
    wr(tec_pkg::OFS_OUTCTL, 16'h0003);
    wr(tec_pkg::OFS_IRQ_CLR, bitv(tec_pkg::IRQ_DUTY));
    wr(tec_pkg::OFS_IRQ_EN, bitv(tec_pkg::IRQ_DUTY));
    pm.span(1'b0, x);
    pm.span(1'b1, hi);
    pm.span(1'b0, lo);
    check(16'(hi + lo), 16'(p + 1));
    check({15'h0000, hi == d + 1 || hi == p - d}, 16'h0001);
    // inversion off: only the period match toggles
    wr(tec_pkg::OFS_OUTCTL, 16'h0002);
    pm.span(1'b0, x);
    pm.span(1'b1, hi);
    pm.span(1'b0, lo);
    check(16'(hi), 16'(p + 1));
    check(16'(lo), 16'(p + 1));
    // stop and clear the sticky flags
    wr(tec_pkg::OFS_MODE, 16'h0000);
    wr(tec_pkg::OFS_IRQ_CLR, 16'h000f);
    rd(tec_pkg::OFS_IRQ_STAT, got);
    check(got, 16'h0000);
    check({15'h0000, irq}, 16'h0000);
    // one-shot by software trigger, again only after completion
    wr(tec_pkg::OFS_OUTCTL, 16'h0003);
    wr(tec_pkg::OFS_MODE, mode_w(tec_pkg::FN_ONESHOT, tec_pkg::EDGE_NONE, 1'b1, 2'h1));
    wr(tec_pkg::OFS_OUTCTL, 16'h0007);
    pm.span(1'b1, hi);
    check(16'(hi), 16'(p - d));
    rd(tec_pkg::OFS_OUTCTL, got);
    check(got, 16'h0003);
    k = 0;
    repeat (3 * (p + 1)) begin
      tick(1);
      #1 k += (tout === 1'b1) ? 1 : 0;
    end
    check(16'(k), 16'h0000);
    wr(tec_pkg::OFS_OUTCTL, 16'h0007);
    pm.span(1'b1, hi);
    check(16'(hi), 16'(p - d));
    close_out();
  end
endmodule
